/* File: src/cps_regs.sv */
// What this block does
// - Low eight program counter bits appear at data address 02h, read and write.
// - Program counter spans 4,096 words and steps by one per instruction cycle, by two on skip.
// - Status at 03h: page bits 7-5, timeout 4, power-down 3, Z, DC, C.
// - Software writes never change the timeout and power-down flags.
// - Timeout flag: 1 at power-up, 0 on expiry, 1 on watchdog clear or sleep.
// - Power-down flag: 1 at power-up, 0 on sleep, 1 on watchdog clear.
// - Page bits feed counter top on jump or call; page instruction sets only them.
// - Arithmetic, move and logic ops set zero flag exactly when result is zero.
// - Digit carry: add sets on nibble carry; subtract clears on nibble borrow.
// - Carry: add sets on carry out of bit 7; subtract clears on borrow.
// - A fuse bit chooses whether carry enters add and subtract; default excludes it.
// - Rotate right loads carry from bit 0, rotate left from bit 7.
// - Semi-direct access: pointer upper bits pick bank, opcode picks register.
// - Address 00h accesses the register whose address the pointer holds.
// - Indirect 01h-0Fh hit global bank, higher hit banks 1-F; bank 0 never.
`include "cps_map.svh"

module cps_regs (
	input wire logic clk_sys_i,
	input wire logic rst_i,
	input wire logic step_i,
	input wire logic [4:0] dat_addr_i,
	input wire logic dat_wr_i,
	input wire logic [7:0] dat_wdata_i,
	input wire logic skip_i,
	input wire logic jump_i,
	input wire logic [8:0] jump_target_i,
	input wire logic page_i,
	input wire logic [2:0] page_val_i,
	input wire logic wdt_expire_i,
	input wire logic clrwdt_i,
	input wire logic sleep_i,
	input wire cps_pkg::cps_op_t op_i,
	input wire logic [7:0] opa_i,
	input wire logic [7:0] opb_i,
	input wire logic carry_in_fuse_n_i,
	output cps_pkg::cps_loc_t eff_loc_o,
	output logic [7:0] dat_rdata_o,
	output logic dat_hit_o,
	output logic [7:0] alu_result_o,
	output logic [`CPS_PC_W-1:0] pc_o,
	output logic [7:0] status_o,
	output logic [7:0] file_bank_pointer_o
);

	// ***********************************************
	// Registers
	// ***********************************************
	logic [`CPS_PC_W-1:0] pc_r;
	logic [`CPS_PC_W-1:0] pc_nxt;
	logic [7:0] st_r;
	logic [7:0] st_nxt;
	logic [7:0] fsr_r;
	logic [7:0] res_r;
	cps_pkg::cps_alu_t alu;

	// ***********************************************
	// Address resolution
	// ***********************************************
	wire indirect = (dat_addr_i == `CPS_ADR_INDIRECT);
	wire semi_bank = dat_addr_i[`CPS_SEMI_BANK_BIT];
	wire [3:0] ind_bank = fsr_r[7:4];
	cps_pkg::cps_loc_t loc;
	assign loc.global_hit = indirect ? (ind_bank == `CPS_GLOBAL_BANK) : !semi_bank;
	assign loc.bank = indirect ? ind_bank : (semi_bank ? fsr_r[7:4] : `CPS_GLOBAL_BANK);
	assign loc.idx = indirect ? fsr_r[3:0] : dat_addr_i[3:0];
	assign eff_loc_o = loc;

	wire hit_pcl = loc.global_hit && (loc.idx == `CPS_ADR_PCL);
	wire hit_st = loc.global_hit && (loc.idx == `CPS_ADR_STATUS);
	wire hit_fsr = loc.global_hit && (loc.idx == `CPS_ADR_FSR);
	wire wr = step_i && dat_wr_i;
	assign dat_hit_o = hit_pcl || hit_st || hit_fsr;
	assign dat_rdata_o = hit_pcl ? pc_r[7:0] : hit_st ? st_r : hit_fsr ? fsr_r
		: `CPS_BYTE_ZERO;

	// ***********************************************
	// Flag arithmetic
	// ***********************************************
	cps_alu u_alu (
		.op_i(op_i),
		.opa_i(opa_i),
		.opb_i(opb_i),
		.carry_i(st_r[`CPS_ST_C]),
		.use_carry_i(!carry_in_fuse_n_i),
		.out_o(alu)
	);

	wire is_arith = (op_i == cps_pkg::CPS_OP_ADD) || (op_i == cps_pkg::CPS_OP_SUB);
	wire is_rot = (op_i == cps_pkg::CPS_OP_RR) || (op_i == cps_pkg::CPS_OP_RL);
	wire z_upd = step_i && (op_i != cps_pkg::CPS_OP_NONE) && !is_rot;
	wire dc_upd = step_i && is_arith;
	wire c_upd = step_i && (is_arith || is_rot);

	// ***********************************************
	// Status next value
	// ***********************************************
	always_comb begin
		st_nxt = st_r;
		if (wr && hit_st)
			st_nxt = (dat_wdata_i & ~`CPS_ST_RO_MASK) | (st_r & `CPS_ST_RO_MASK);
		if (step_i && page_i)
			st_nxt[`CPS_ST_PA_HI:`CPS_ST_PA_LO] = page_val_i;
		if (z_upd)
			st_nxt[`CPS_ST_Z] = (alu.res == `CPS_BYTE_ZERO);
		if (dc_upd)
			st_nxt[`CPS_ST_DC] = alu.digit_carry;
		if (c_upd)
			st_nxt[`CPS_ST_C] = alu.carry;
		if (step_i && wdt_expire_i)
			st_nxt[`CPS_ST_TO] = 1'b0;
		if (step_i && (clrwdt_i || sleep_i))
			st_nxt[`CPS_ST_TO] = 1'b1;
		if (step_i && sleep_i)
			st_nxt[`CPS_ST_PD] = 1'b0;
		if (step_i && clrwdt_i)
			st_nxt[`CPS_ST_PD] = 1'b1;
	end

	// ***********************************************
	// Program counter next value
	// ***********************************************
	always_comb begin
		pc_nxt = pc_r;
		if (step_i) begin
			if (jump_i)
				pc_nxt = {st_r[`CPS_ST_PA_HI:`CPS_ST_PA_LO], jump_target_i};
			else if (wr && hit_pcl)
				pc_nxt = {pc_r[`CPS_PC_W-1:8], dat_wdata_i};
			else if (skip_i)
				pc_nxt = pc_r + `CPS_PC_TWO;
			else
				pc_nxt = pc_r + `CPS_PC_ONE;
		end
	end

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			pc_r <= `CPS_PC_RST;
			st_r <= `CPS_ST_RST;
			fsr_r <= `CPS_FSR_RST;
			res_r <= `CPS_BYTE_ZERO;
		end else begin
			pc_r <= pc_nxt;
			st_r <= st_nxt;
			if (wr && hit_fsr)
				fsr_r <= dat_wdata_i;
			if (step_i)
				res_r <= alu.res;
		end
	end

	assign pc_o = pc_r;
	assign status_o = st_r;
	assign file_bank_pointer_o = fsr_r;
	assign alu_result_o = res_r;

	// ***********************************************
	// Checks
	// ***********************************************
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (rst_i);

	sequence s_plain_step;
		step_i && !jump_i && !skip_i && !(dat_wr_i && hit_pcl);
	endsequence
	sequence s_sleep_only;
		step_i && sleep_i && !clrwdt_i;
	endsequence
	sequence s_expire_only;
		step_i && wdt_expire_i && !clrwdt_i && !sleep_i;
	endsequence
	sequence s_status_write;
		step_i && dat_wr_i && hit_st;
	endsequence

	chk_pc_step: assert property (s_plain_step |=> pc_r == $past(pc_r) + `CPS_PC_ONE)
		else $error("pc did not advance by one");
	chk_pc_skip: assert property (step_i && skip_i && !jump_i && !(dat_wr_i && hit_pcl)
		|=> pc_r == $past(pc_r) + `CPS_PC_TWO)
		else $error("skip did not advance pc by two");
	chk_jump_page: assert property (step_i && jump_i
		|=> pc_r[`CPS_PC_W-1:`CPS_PC_PAGE_LSB] == $past(st_r[`CPS_ST_PA_HI:`CPS_ST_PA_LO]))
		else $error("jump top bits not from page select");
	chk_ro_flags: assert property (step_i && dat_wr_i && hit_st && !wdt_expire_i
		&& !clrwdt_i && !sleep_i |=> $stable(st_r[`CPS_ST_TO:`CPS_ST_PD]))
		else $error("software write changed read-only flags");
	chk_to_expire: assert property (s_expire_only |=> !st_r[`CPS_ST_TO])
		else $error("timeout flag not cleared on expiry");
	chk_pd_sleep: assert property (s_sleep_only |=> !st_r[`CPS_ST_PD] && st_r[`CPS_ST_TO])
		else $error("sleep did not set power-down state");
	chk_zero_flag: assert property (z_upd |=> st_r[`CPS_ST_Z] == (alu_result_o == `CPS_BYTE_ZERO))
		else $error("zero flag disagrees with result");
	chk_indirect_addr: assert property (indirect |-> eff_loc_o.idx == fsr_r[3:0]
		&& eff_loc_o.global_hit == (fsr_r[7:4] == `CPS_GLOBAL_BANK))
		else $error("indirect access not taken from pointer");
	chk_page_only: assert property (step_i && page_i && op_i == cps_pkg::CPS_OP_NONE
		&& !dat_wr_i && !wdt_expire_i && !clrwdt_i && !sleep_i
		|=> st_r[`CPS_ST_TO:`CPS_ST_C] == $past(st_r[`CPS_ST_TO:`CPS_ST_C]))
		else $error("page instruction disturbed other status bits");
	chk_idle_hold: assert property (!step_i
		|=> pc_r == $past(pc_r) && st_r == $past(st_r)
		&& fsr_r == $past(fsr_r) && res_r == $past(res_r))
		else $error("state changed without an instruction step");
	chk_pcl_write: assert property (step_i && dat_wr_i && hit_pcl && !jump_i
		|=> pc_r[7:0] == $past(dat_wdata_i) && pc_r[`CPS_PC_W-1:8] == $past(pc_r[`CPS_PC_W-1:8]))
		else $error("program counter low byte write lost");
	chk_rr_carry: assert property (step_i && op_i == cps_pkg::CPS_OP_RR
		|=> st_r[`CPS_ST_C] == $past(opa_i[0]))
		else $error("rotate right did not load carry from bit 0");
	chk_rl_carry: assert property (step_i && op_i == cps_pkg::CPS_OP_RL
		|=> st_r[`CPS_ST_C] == $past(opa_i[7]))
		else $error("rotate left did not load carry from bit 7");
	chk_fsr_write: assert property (step_i && dat_wr_i && hit_fsr
		|=> fsr_r == $past(dat_wdata_i))
		else $error("pointer write lost");
	chk_semi_bank: assert property (dat_addr_i[`CPS_SEMI_BANK_BIT]
		|-> eff_loc_o.bank == fsr_r[7:4] && !eff_loc_o.global_hit && eff_loc_o.idx == dat_addr_i[3:0])
		else $error("semi-direct access not banked by pointer");
	chk_clear_flags: assert property (step_i && clrwdt_i
		|=> st_r[`CPS_ST_TO] && st_r[`CPS_ST_PD])
		else $error("watchdog clear did not set timeout and power-down flags");
	chk_flag_wins: assert property (s_status_write ##0 z_upd
		|=> st_r[`CPS_ST_Z] == $past(alu.res == `CPS_BYTE_ZERO))
		else $error("status write overrode zero flag update");

endmodule // cps_regs

/* File: pkg/cps_map.svh */
`ifndef CPS_MAP_SVH
`define CPS_MAP_SVH

// ***********************************************
// Data addresses
// ***********************************************
`define CPS_ADR_INDIRECT 5'h00
`define CPS_ADR_PCL 4'h2
`define CPS_ADR_STATUS 4'h3
`define CPS_ADR_FSR 4'h4
`define CPS_SEMI_BANK_BIT 4
`define CPS_GLOBAL_BANK 4'h0

// ***********************************************
// Program counter
// ***********************************************
`define CPS_PC_W 12
`define CPS_PC_RST 12'hfff
`define CPS_PC_ONE 12'h001
`define CPS_PC_TWO 12'h002
`define CPS_PC_PAGE_LSB 9

// ***********************************************
// Status fields and reset values
// ***********************************************
`define CPS_ST_C 0
`define CPS_ST_DC 1
`define CPS_ST_Z 2
`define CPS_ST_PD 3
`define CPS_ST_TO 4
`define CPS_ST_PA_LO 5
`define CPS_ST_PA_HI 7
`define CPS_ST_RO_MASK 8'h18
`define CPS_ST_RST 8'h18
`define CPS_FSR_RST 8'h00
`define CPS_BYTE_ZERO 8'h00
`define CPS_BYTE_ONE 8'h01

`endif

/* File: pkg/cps_pkg.sv */
package cps_pkg;

	// ***********************************************
	// Flag-affecting operations
	// ***********************************************
	typedef enum logic [3:0] {
		CPS_OP_NONE = 4'h0,
		CPS_OP_MOVE = 4'h1,
		CPS_OP_AND = 4'h2,
		CPS_OP_OR = 4'h3,
		CPS_OP_XOR = 4'h4,
		CPS_OP_ADD = 4'h5,
		CPS_OP_SUB = 4'h6,
		CPS_OP_INC = 4'h7,
		CPS_OP_DEC = 4'h8,
		CPS_OP_RR = 4'h9,
		CPS_OP_RL = 4'ha
	} cps_op_t;

	// Resolved data location
	typedef struct packed {
		logic global_hit;
		logic [3:0] bank;
		logic [3:0] idx;
	} cps_loc_t;

	// ALU answer
	typedef struct packed {
		logic [7:0] res;
		logic carry;
		logic digit_carry;
	} cps_alu_t;

endpackage

/* File: src/cps_alu.sv */
`include "cps_map.svh"

module cps_alu (
	input wire cps_pkg::cps_op_t op_i,
	input wire logic [7:0] opa_i,
	input wire logic [7:0] opb_i,
	input wire logic carry_i,
	input wire logic use_carry_i,
	output cps_pkg::cps_alu_t out_o
);

	function automatic logic [4:0] nib_add(input logic [3:0] x, input logic [3:0] y,
		input logic ci);
		nib_add = {1'b0, x} + {1'b0, y} + {4'h0, ci};
	endfunction

	wire is_sub = (op_i == cps_pkg::CPS_OP_SUB);
	wire [7:0] b_eff = is_sub ? ~opb_i : opb_i;
	// Subtract is a + ~b + 1 unless the carry chain is enabled
	wire cin = use_carry_i ? carry_i : is_sub;
	wire [4:0] lo = nib_add(opa_i[3:0], b_eff[3:0], cin);
	wire [4:0] hi = nib_add(opa_i[7:4], b_eff[7:4], lo[4]);

	always_comb begin
		out_o.res = opa_i;
		out_o.carry = carry_i;
		out_o.digit_carry = lo[4];
		case (op_i)
			cps_pkg::CPS_OP_MOVE: out_o.res = opb_i;
			cps_pkg::CPS_OP_AND: out_o.res = opa_i & opb_i;
			cps_pkg::CPS_OP_OR: out_o.res = opa_i | opb_i;
			cps_pkg::CPS_OP_XOR: out_o.res = opa_i ^ opb_i;
			cps_pkg::CPS_OP_ADD, cps_pkg::CPS_OP_SUB: begin
				out_o.res = {hi[3:0], lo[3:0]};
				out_o.carry = hi[4];
			end
			cps_pkg::CPS_OP_INC: out_o.res = opa_i + `CPS_BYTE_ONE;
			cps_pkg::CPS_OP_DEC: out_o.res = opa_i - `CPS_BYTE_ONE;
			cps_pkg::CPS_OP_RR: begin
				out_o.res = {carry_i, opa_i[7:1]};
				out_o.carry = opa_i[0];
			end
			cps_pkg::CPS_OP_RL: begin
				out_o.res = {opa_i[6:0], carry_i};
				out_o.carry = opa_i[7];
			end
			default: out_o.res = opa_i;
		endcase
	end

endmodule // cps_alu

/* File: sim/test_cps_regs.sv */
module test_cps_regs;
	timeunit 1ns;
	timeprecision 1ps;
	// ***********************************************
	// Signals
	// ***********************************************
	logic clk_sys_i = 1'b0;
	logic rst_i = 1'b1;
	logic step_i = 1'b0;
	logic dat_wr_i = 1'b0;
	logic skip_i = 1'b0;
	logic jump_i = 1'b0;
	logic page_i = 1'b0;
	logic wdt_expire_i = 1'b0;
	logic clrwdt_i = 1'b0;
	logic sleep_i = 1'b0;
	logic carry_in_fuse_n_i = 1'b1;
	logic [4:0] dat_addr_i = 5'h00;
	logic [7:0] dat_wdata_i = 8'h00;
	logic [7:0] opa_i = 8'h00;
	logic [7:0] opb_i = 8'h00;
	logic [8:0] jump_target_i = 9'h000;
	logic [2:0] page_val_i = 3'h0;
	cps_pkg::cps_op_t op_i = cps_pkg::CPS_OP_NONE;
	cps_pkg::cps_loc_t eff_loc_o;
	logic [7:0] dat_rdata_o;
	logic dat_hit_o;
	logic [7:0] alu_result_o;
	logic [11:0] pc_o;
	logic [7:0] status_o;
	logic [7:0] file_bank_pointer_o;
	int fails = 0;
	int comparisons = 0;
	logic [11:0] exp_pc = 12'hfff;
	logic [2:0] exp_pa = 3'h0;
	// Op, a, b, result, {0,zero,digit carry,carry}
	logic [31:0] tbl [18] = '{32'h50f01102, 32'h5ff01007, 32'h610010f1, 32'h60505007,
		32'h60001ff0, 32'h2f00f004, 32'h3f00fff0, 32'h4aaaa004, 32'h1ff00004,
		32'h7ff00004, 32'h80100004, 32'h90100005, 32'ha8000015, 32'h50101020,
		32'h90200010, 32'h60505ff0, 32'h5ff01007, 32'h50101030};

	cps_regs uut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .step_i(step_i),
		.dat_addr_i(dat_addr_i), .dat_wr_i(dat_wr_i), .dat_wdata_i(dat_wdata_i),
		.skip_i(skip_i), .jump_i(jump_i), .jump_target_i(jump_target_i), .page_i(page_i),
		.page_val_i(page_val_i), .wdt_expire_i(wdt_expire_i), .clrwdt_i(clrwdt_i),
		.sleep_i(sleep_i), .op_i(op_i), .opa_i(opa_i), .opb_i(opb_i),
		.carry_in_fuse_n_i(carry_in_fuse_n_i), .eff_loc_o(eff_loc_o),
		.dat_rdata_o(dat_rdata_o), .dat_hit_o(dat_hit_o), .alu_result_o(alu_result_o),
		.pc_o(pc_o), .status_o(status_o), .file_bank_pointer_o(file_bank_pointer_o));

	// ***********************************************
	// Tasks
	// ***********************************************
	task automatic chk(input logic [11:0] got, input logic [11:0] exp);
		comparisons++;
		if (got !== exp) begin
			fails++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic end_sim;
		$display("comparisons=%0d fails=%0d", comparisons, fails);
		if (fails == 0 && comparisons > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	// One instruction step; events are {skip,jump,page,expire,clear,sleep}
	task automatic run(input logic [4:0] ad, input logic wr, input logic [7:0] wd,
		input logic [5:0] ev, input logic [3:0] op, input logic [7:0] a, input logic [7:0] b);
		@(posedge clk_sys_i);
		step_i <= 1'b1;
		dat_addr_i <= ad;
		dat_wr_i <= wr;
		dat_wdata_i <= wd;
		{skip_i, jump_i, page_i, wdt_expire_i, clrwdt_i, sleep_i} <= ev;
		op_i <= cps_pkg::cps_op_t'(op);
		opa_i <= a;
		opb_i <= b;
		if (ev[4]) exp_pc = {exp_pa, jump_target_i};
		else if (wr && ad == 5'h02) exp_pc[7:0] = wd;
		else if (ev[5]) exp_pc = exp_pc + 12'h002;
		else exp_pc = exp_pc + 12'h001;
		if (ev[3]) exp_pa = page_val_i;
		else if (wr && ad == 5'h03) exp_pa = wd[7:5];
		@(posedge clk_sys_i);
		step_i <= 1'b0;
		dat_wr_i <= 1'b0;
		{skip_i, jump_i, page_i, wdt_expire_i, clrwdt_i, sleep_i} <= 6'h00;
		#1;
		chk(pc_o, exp_pc);
	endtask

	task automatic rd(input logic [4:0] ad, input logic [7:0] exp);
		@(posedge clk_sys_i);
		dat_addr_i <= ad;
		#1;
		chk(12'(dat_rdata_o), 12'(exp));
	endtask

	// ***********************************************
	// Tests
	// ***********************************************
	initial forever #10 clk_sys_i = ~clk_sys_i;

	initial begin
		repeat (5000) @(posedge clk_sys_i);
		fails++;
		end_sim;
	end

	initial begin
		logic [31:0] e;
		repeat (16) @(posedge clk_sys_i);
		rst_i <= 1'b0;
		#1;
		chk(pc_o, 12'hfff);
		chk(12'(status_o), 12'h018);
		chk(12'(file_bank_pointer_o), 12'h000);
		$display("test reset done");
		run(5'h03, 1'b1, 8'h00, 6'h00, 4'h0, 8'h00, 8'h00);
		chk(12'(status_o), 12'h018);
		run(5'h03, 1'b1, 8'hff, 6'h00, 4'h0, 8'h00, 8'h00);
		rd(5'h03, 8'hff);
		run(5'h03, 1'b1, 8'h00, 6'h00, 4'h0, 8'h00, 8'h00);
		$display("test status write done");
		for (int i = 0; i < 18; i++) begin
			e = tbl[i];
			if (i == 15) @(posedge clk_sys_i) carry_in_fuse_n_i <= 1'b0;
			run(5'h01, 1'b0, 8'h00, 6'h00, e[31:28], e[27:20], e[19:12]);
			chk(12'(alu_result_o), 12'(e[11:4]));
			chk(12'(status_o), 12'(8'h18 | {4'h0, e[3:0]}));
		end
		@(posedge clk_sys_i) carry_in_fuse_n_i <= 1'b1;
		$display("test flags done");
		@(posedge clk_sys_i) begin
			page_val_i <= 3'h5;
			jump_target_i <= 9'h1a3;
		end
		run(5'h01, 1'b0, 8'h00, 6'h08, 4'h0, 8'h00, 8'h00);
		chk(12'(status_o), 12'h0b8);
		run(5'h03, 1'b1, 8'h00, 6'h08, 4'h0, 8'h00, 8'h00);
		chk(12'(status_o), 12'h0b8);
		run(5'h01, 1'b0, 8'h00, 6'h10, 4'h0, 8'h00, 8'h00);
		chk(pc_o, 12'hba3);
		run(5'h01, 1'b0, 8'h00, 6'h20, 4'h0, 8'h00, 8'h00);
		run(5'h02, 1'b1, 8'h3c, 6'h00, 4'h0, 8'h00, 8'h00);
		rd(5'h02, 8'h3c);
		run(5'h03, 1'b1, 8'hff, 6'h00, 4'h5, 8'h0f, 8'h01);
		chk(12'(status_o), 12'h0fa);
		$display("test counter done");
		run(5'h01, 1'b0, 8'h00, 6'h04, 4'h0, 8'h00, 8'h00);
		chk(12'(status_o[4:3]), 12'h001);
		run(5'h01, 1'b0, 8'h00, 6'h01, 4'h0, 8'h00, 8'h00);
		chk(12'(status_o[4:3]), 12'h002);
		run(5'h01, 1'b0, 8'h00, 6'h02, 4'h0, 8'h00, 8'h00);
		chk(12'(status_o[4:3]), 12'h003);
		run(5'h01, 1'b0, 8'h00, 6'h06, 4'h0, 8'h00, 8'h00);
		chk(12'(status_o[4:3]), 12'h003);
		$display("test events done");
		run(5'h04, 1'b1, 8'h37, 6'h00, 4'h0, 8'h00, 8'h00);
		rd(5'h15, 8'h00);
		chk(12'(eff_loc_o), 12'h035);
		rd(5'h00, 8'h00);
		chk(12'(eff_loc_o), 12'h037);
		run(5'h04, 1'b1, 8'h03, 6'h00, 4'h0, 8'h00, 8'h00);
		rd(5'h00, 8'hfa);
		chk(12'({dat_hit_o, eff_loc_o}), 12'h303);
		run(5'h04, 1'b1, 8'h04, 6'h00, 4'h0, 8'h00, 8'h00);
		run(5'h00, 1'b1, 8'h5a, 6'h00, 4'h0, 8'h00, 8'h00);
		chk(12'(file_bank_pointer_o), 12'h05a);
		$display("test addressing done");
		@(posedge clk_sys_i) rst_i <= 1'b1;
		@(posedge clk_sys_i) rst_i <= 1'b0;
		#1;
		chk(pc_o, 12'hfff);
		chk(12'(status_o), 12'h018);
		chk(12'(file_bank_pointer_o), 12'h000);
		$display("test second reset done");
		end_sim;
	end
endmodule // test_cps_regs
